// *** shared/psm_pkg.sv ***
/*
  Constants and types for the power and system management block.
  Assumes a single 200 MHz system clock and a synchronous active-high reset.
*/
package psm_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned PSM_CLK_MHZ = 200;
  localparam int unsigned PSM_CNT_W = 32;
  // least button pulse width
  localparam int unsigned PSM_BTN_MIN_MS = 16;
  localparam int unsigned PSM_BTN_MIN_CYC = PSM_BTN_MIN_MS * 1000 * PSM_CLK_MHZ;
  // least width of a status level change
  localparam int unsigned PSM_STATUS_MIN_NS = 100;
  localparam int unsigned PSM_STATUS_MIN_CYC = (PSM_STATUS_MIN_NS * PSM_CLK_MHZ + 999) / 1000;
  // carrier reset pulse length
  localparam int unsigned PSM_RST_PULSE_US = 1000;
  localparam int unsigned PSM_RST_PULSE_CYC = PSM_RST_PULSE_US * PSM_CLK_MHZ;
  // lead time of the imminent-suspend indication
  localparam int unsigned PSM_SUSP_PREP_US = 10;
  localparam int unsigned PSM_SUSP_PREP_CYC = PSM_SUSP_PREP_US * PSM_CLK_MHZ;
  // watchdog time-out
  localparam int unsigned PSM_WDT_MS = 1000;
  localparam int unsigned PSM_WDT_CYC = PSM_WDT_MS * 1000 * PSM_CLK_MHZ;

  // ----------------------------------------------------------------
  // qualified input slots
  // ----------------------------------------------------------------
  localparam int unsigned PSM_N_FILT = 9;
  localparam int unsigned PSM_IDX_PWR = 0;
  localparam int unsigned PSM_IDX_RST = 1;
  localparam int unsigned PSM_IDX_LID = 2;
  localparam int unsigned PSM_IDX_SLP = 3;
  localparam int unsigned PSM_IDX_PGOOD = 4;
  localparam int unsigned PSM_IDX_PCIE_WAKE_IN_N = 5;
  localparam int unsigned PSM_IDX_AUX_WAKE_IN_N = 6;
  localparam int unsigned PSM_IDX_BAT = 7;
  localparam int unsigned PSM_IDX_MAINLOW = 8;
  // slots below this index are the buttons and the lid switch, with the long width
  localparam int unsigned PSM_N_BTN = 4;
  // idle level of each slot after reset
  localparam logic [PSM_N_FILT-1:0] PSM_FILT_RST_LVL = 9'h0ef;

  // ----------------------------------------------------------------
  // reset values of the outputs
  // ----------------------------------------------------------------
  localparam logic PSM_RST_CARRIER_N = 1'b0;
  localparam logic PSM_RST_SUSP_IMM_N = 1'b0;
  localparam logic PSM_RST_RAM_N = 1'b1;
  localparam logic PSM_RST_DISK_N = 1'b1;
  localparam logic PSM_RST_OFF_N = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PSM_ST_OFF,
    PSM_ST_ON,
    PSM_ST_PREP,
    PSM_ST_RAM
  } psm_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic level;
    logic fall;
    logic rise;
    logic [PSM_CNT_W-1:0] cnt;
  } psm_filt_t;

  typedef struct packed {
    psm_state_t st;
    logic to_off;
    logic [PSM_CNT_W-1:0] prep_cnt;
    logic [PSM_CNT_W-1:0] rst_cnt;
    logic [PSM_CNT_W-1:0] wdt_cnt;
    logic carrier_rst_n;
    logic susp_imm_n;
    logic ram_n;
    logic disk_n;
    logic off_n;
    logic wdt_exp;
    logic lid_closed;
    logic lid_evt;
    logic bat_low;
    logic bat_evt;
    logic wake_evt;
  } psm_top_t;

endpackage

// *** shared/psm_filt_if.sv ***
/*
  Interface between the manager and one input qualifier.
  Assumes the qualifier and its user share the system clock.
*/
`timescale 1ns/1ps
interface psm_filt_if;
  logic raw;
  logic level;
  logic fall;
  logic rise;

  modport filt (
    input raw,
    output level,
    output fall,
    output rise
  );

  modport user (
    output raw,
    input level,
    input fall,
    input rise
  );
endinterface

// *** rtl/psm_pulse_filter.sv ***
/*
  Input qualifier: two-stage synchroniser, then a level that only follows
  the input once the new value has held for HOLD_CYC cycles.
  Assumes the clock of the manager and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module psm_pulse_filter #(
  parameter int unsigned HOLD_CYC = 16,
  parameter logic RST_LEVEL = 1'b1
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  psm_filt_if.filt io
);
  import psm_pkg::*;

  localparam logic [PSM_CNT_W-1:0] HOLD_LAST = PSM_CNT_W'(HOLD_CYC - 1);

  psm_filt_t q;
  psm_filt_t d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.s1 = io.raw;
    d.s2 = q.s1;
    d.fall = 1'b0;
    d.rise = 1'b0;
    if (q.s2 != q.level) begin
      if (q.cnt >= HOLD_LAST) begin
        d.level = q.s2;
        d.fall = q.level;
        d.rise = ~q.level;
        d.cnt = '0;
      end else begin
        d.cnt = q.cnt + PSM_CNT_W'(1);
      end
    end else begin
      d.cnt = '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      q <= '{s1: RST_LEVEL, s2: RST_LEVEL, level: RST_LEVEL, fall: 1'b0, rise: 1'b0,
             cnt: '0};
    end else begin
      q <= d;
    end
  end

  assign io.level = q.level;
  assign io.fall = q.fall;
  assign io.rise = q.rise;
endmodule

// *** rtl/psm_power_mgr.sv ***
/*
  Power and system management of a plug-in processor module: buttons,
  supply status, wake sources, sleep states, carrier reset and watchdog.
  Assumes all pins are sampled on the 200 MHz system clock and that
  software requests arrive as one-cycle pulses on plain inputs.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - power button falling edge leaves soft-off
// - reset button acts on its falling edge
// - held reset button does not hold reset
// - listed causes all pulse the carrier reset
// - high supply-good means power is good
// - suspend-to-RAM indicator low while suspended
// - soft-off indicator shows soft-off state
// - suspend-to-disk indicator unsupported, held high
// - imminent-suspend asserted before low-power entry
// - pcie wake request wakes the system
// - auxiliary wake input wakes the system
// - low battery input is power event
// - lid switch reported to operating system
// - sleep button enters or leaves sleep
// - watchdog output shows a time-out occurred
module psm_power_mgr #(
  parameter int unsigned BTN_HOLD_CYC = psm_pkg::PSM_BTN_MIN_CYC,
  parameter int unsigned RST_PULSE_CYC = psm_pkg::PSM_RST_PULSE_CYC,
  parameter int unsigned WDT_CYC = psm_pkg::PSM_WDT_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic power_button_n_in,
  input wire logic reset_button_n_in,
  input wire logic lid_n_in,
  input wire logic sleep_button_n_in,
  input wire logic supply_good_in,
  input wire logic pcie_wake_n_in,
  input wire logic aux_wake_n_in,
  input wire logic battery_low_n_in,
  input wire logic main_supply_low_in,
  input wire logic sw_reset_req_in,
  input wire logic sw_sleep_req_in,
  input wire logic sw_off_req_in,
  input wire logic wdt_enable_in,
  input wire logic wdt_kick_in,
  output logic carrier_reset_n_out,
  output logic suspend_imminent_n_out,
  output logic suspend_ram_ind_n_out,
  output logic suspend_disk_ind_n_out,
  output logic soft_off_ind_n_out,
  output logic watchdog_expired_out,
  output logic lid_closed_out,
  output logic lid_event_out,
  output logic battery_low_out,
  output logic battery_event_out,
  output logic wake_event_out
);
  import psm_pkg::*;

  localparam logic [PSM_CNT_W-1:0] RST_LOAD = PSM_CNT_W'(RST_PULSE_CYC);
  localparam logic [PSM_CNT_W-1:0] WDT_LAST = PSM_CNT_W'(WDT_CYC - 1);
  localparam logic [PSM_CNT_W-1:0] PREP_LAST = PSM_CNT_W'(PSM_SUSP_PREP_CYC - 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic int unsigned hold_for(input int unsigned idx);
    if (idx < PSM_N_BTN) begin
      hold_for = BTN_HOLD_CYC;
    end else begin
      hold_for = PSM_STATUS_MIN_CYC;
    end
  endfunction

  function automatic logic is_state(input psm_state_t cur, input psm_state_t ref_st);
    is_state = (cur == ref_st);
  endfunction

  function automatic logic [PSM_CNT_W-1:0] cnt_up(input logic [PSM_CNT_W-1:0] v);
    cnt_up = v + PSM_CNT_W'(1);
  endfunction

  function automatic logic [PSM_CNT_W-1:0] cnt_down(input logic [PSM_CNT_W-1:0] v);
    cnt_down = v - PSM_CNT_W'(1);
  endfunction

  // ----------------------------------------------------------------
  // input qualification
  // ----------------------------------------------------------------
  logic [PSM_N_FILT-1:0] raw_vec;
  logic [PSM_N_FILT-1:0] lvl;
  logic [PSM_N_FILT-1:0] fall;
  logic [PSM_N_FILT-1:0] rise;

  assign raw_vec[PSM_IDX_PWR] = power_button_n_in;
  assign raw_vec[PSM_IDX_RST] = reset_button_n_in;
  assign raw_vec[PSM_IDX_LID] = lid_n_in;
  assign raw_vec[PSM_IDX_SLP] = sleep_button_n_in;
  assign raw_vec[PSM_IDX_PGOOD] = supply_good_in;
  assign raw_vec[PSM_IDX_PCIE_WAKE_IN_N] = pcie_wake_n_in;
  assign raw_vec[PSM_IDX_AUX_WAKE_IN_N] = aux_wake_n_in;
  assign raw_vec[PSM_IDX_BAT] = battery_low_n_in;
  assign raw_vec[PSM_IDX_MAINLOW] = main_supply_low_in;

  psm_filt_if filt_if [PSM_N_FILT] ();

  for (genvar g = 0; g < PSM_N_FILT; g++) begin : g_filt
    assign filt_if[g].raw = raw_vec[g];
    psm_pulse_filter #(
      .HOLD_CYC(hold_for(g)),
      .RST_LEVEL(PSM_FILT_RST_LVL[g])
    ) u_filt (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .io(filt_if[g])
    );
    assign lvl[g] = filt_if[g].level;
    assign fall[g] = filt_if[g].fall;
    assign rise[g] = filt_if[g].rise;
  end

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  logic pwr_evt;
  logic slp_evt;
  logic wake_any;
  logic bat_evt;
  logic supply_ok;
  logic wake_pcie;
  logic wake_aux;
  logic rst_by_btn;
  logic rst_by_supply;
  logic rst_by_main;

  assign pwr_evt = fall[PSM_IDX_PWR];
  assign slp_evt = fall[PSM_IDX_SLP];
  assign bat_evt = fall[PSM_IDX_BAT];
  assign supply_ok = lvl[PSM_IDX_PGOOD];
  assign wake_pcie = fall[PSM_IDX_PCIE_WAKE_IN_N];
  assign wake_aux = fall[PSM_IDX_AUX_WAKE_IN_N];
  assign wake_any = pwr_evt | slp_evt | wake_pcie | wake_aux;
  assign rst_by_btn = fall[PSM_IDX_RST];
  assign rst_by_supply = fall[PSM_IDX_PGOOD];
  assign rst_by_main = rise[PSM_IDX_MAINLOW];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  psm_top_t q;
  psm_top_t d;
  logic wdt_to;
  logic rst_evt;
  logic rst_hold;

  always_comb begin
    d = q;
    wdt_to = 1'b0;
    rst_evt = 1'b0;
    rst_hold = 1'b0;

    // ----------------------------------------------------------------
    // watchdog counts only while running
    // ----------------------------------------------------------------
    if (is_state(q.st, PSM_ST_ON) && wdt_enable_in) begin
      if (wdt_kick_in) begin
        d.wdt_cnt = '0;
      end else if (q.wdt_cnt >= WDT_LAST) begin
        d.wdt_cnt = '0;
        wdt_to = 1'b1;
      end else begin
        d.wdt_cnt = cnt_up(q.wdt_cnt);
      end
    end else begin
      d.wdt_cnt = '0;
    end

    // ----------------------------------------------------------------
    // watchdog flag: a same-cycle kick suppresses the time-out
    // ----------------------------------------------------------------
    if (wdt_kick_in) begin
      d.wdt_exp = 1'b0;
    end
    if (wdt_to) begin
      d.wdt_exp = 1'b1;
    end

    // ----------------------------------------------------------------
    // power state sequence
    // ----------------------------------------------------------------
    case (q.st)
      PSM_ST_OFF: begin
        if (pwr_evt && supply_ok) begin
          d.st = PSM_ST_ON;
        end
      end

      PSM_ST_ON: begin
        d.prep_cnt = '0;
        if (pwr_evt || sw_off_req_in) begin
          d.st = PSM_ST_PREP;
          d.to_off = 1'b1;
        end else if (slp_evt || sw_sleep_req_in || bat_evt) begin
          d.st = PSM_ST_PREP;
          d.to_off = 1'b0;
        end
      end

      PSM_ST_PREP: begin
        if (q.prep_cnt >= PREP_LAST) begin
          d.st = q.to_off ? PSM_ST_OFF : PSM_ST_RAM;
          d.prep_cnt = '0;
        end else begin
          d.prep_cnt = cnt_up(q.prep_cnt);
        end
      end

      PSM_ST_RAM: begin
        if (wake_any) begin
          d.st = PSM_ST_ON;
        end
      end
      default: begin
        d.st = PSM_ST_OFF;
      end
    endcase

    // ----------------------------------------------------------------
    // carrier reset: edges start a pulse, a held button does not extend it
    // ----------------------------------------------------------------
    rst_evt = rst_by_btn
            | rst_by_supply
            | (~supply_ok & q.carrier_rst_n)
            | rst_by_main
            | wdt_to
            | sw_reset_req_in;
    if (rst_evt) begin
      d.rst_cnt = RST_LOAD;
    end else if (q.rst_cnt != '0) begin
      d.rst_cnt = cnt_down(q.rst_cnt);
    end
    rst_hold = ~supply_ok;
    rst_hold = rst_hold | lvl[PSM_IDX_MAINLOW];
    rst_hold = rst_hold | ~is_state(d.st, PSM_ST_ON);
    d.carrier_rst_n = ~(rst_hold | (d.rst_cnt != '0));

    // ----------------------------------------------------------------
    // state indicators
    // ----------------------------------------------------------------
    d.susp_imm_n = is_state(d.st, PSM_ST_ON);
    d.ram_n = ~is_state(d.st, PSM_ST_RAM);
    d.disk_n = PSM_RST_DISK_N;
    d.off_n = ~is_state(d.st, PSM_ST_OFF);

    // ----------------------------------------------------------------
    // status reporting
    // ----------------------------------------------------------------
    d.lid_closed = ~lvl[PSM_IDX_LID];
    d.lid_evt = fall[PSM_IDX_LID] | rise[PSM_IDX_LID];
    d.bat_low = ~lvl[PSM_IDX_BAT];
    d.bat_evt = bat_evt;
    d.wake_evt = is_state(q.st, PSM_ST_RAM) & wake_any;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      q <= '{
        st: PSM_ST_OFF,
        to_off: 1'b0,
        prep_cnt: '0,
        rst_cnt: '0,
        wdt_cnt: '0,
        carrier_rst_n: PSM_RST_CARRIER_N,
        susp_imm_n: PSM_RST_SUSP_IMM_N,
        ram_n: PSM_RST_RAM_N,
        disk_n: PSM_RST_DISK_N,
        off_n: PSM_RST_OFF_N,
        wdt_exp: 1'b0,
        lid_closed: 1'b0,
        lid_evt: 1'b0,
        bat_low: 1'b0,
        bat_evt: 1'b0,
        wake_evt: 1'b0
      };
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign carrier_reset_n_out = q.carrier_rst_n;
  assign suspend_imminent_n_out = q.susp_imm_n;
  assign suspend_ram_ind_n_out = q.ram_n;
  assign suspend_disk_ind_n_out = q.disk_n;
  assign soft_off_ind_n_out = q.off_n;
  assign watchdog_expired_out = q.wdt_exp;
  assign lid_closed_out = q.lid_closed;
  assign lid_event_out = q.lid_evt;
  assign battery_low_out = q.bat_low;
  assign battery_event_out = q.bat_evt;
  assign wake_event_out = q.wake_evt;
endmodule

// *** verification/psm_power_mgr_asserts.sv ***
/*
  Port checker for psm_power_mgr, bound to every instance.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module psm_power_mgr_asserts
  import psm_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic lid_n_in,
  input wire logic sw_reset_req_in,
  input wire logic wdt_kick_in,
  input wire logic carrier_reset_n_out,
  input wire logic suspend_imminent_n_out,
  input wire logic suspend_ram_ind_n_out,
  input wire logic suspend_disk_ind_n_out,
  input wire logic soft_off_ind_n_out,
  input wire logic watchdog_expired_out,
  input wire logic lid_closed_out,
  input wire logic lid_event_out,
  input wire logic battery_low_out,
  input wire logic battery_event_out,
  input wire logic wake_event_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------------------------------
  // lead time of the imminent-suspend indication
  // ----------------------------------------------------------------
  logic [31:0] prep_q;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || suspend_imminent_n_out || !suspend_ram_ind_n_out || !soft_off_ind_n_out) begin
      prep_q <= '0;
    end else begin
      prep_q <= prep_q + 32'h1;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_disk; suspend_disk_ind_n_out; endproperty
  property p_on_ind;
    carrier_reset_n_out |-> suspend_imminent_n_out && suspend_ram_ind_n_out && soft_off_ind_n_out;
  endproperty
  property p_ram; !suspend_ram_ind_n_out |-> soft_off_ind_n_out && !suspend_imminent_n_out;
  endproperty
  property p_prep;
    $fell(suspend_ram_ind_n_out) || $fell(soft_off_ind_n_out) |->
      prep_q >= PSM_SUSP_PREP_CYC - 1 && prep_q <= PSM_SUSP_PREP_CYC + 1;
  endproperty
  property p_swrst; sw_reset_req_in |=> !carrier_reset_n_out; endproperty
  property p_wdt_hold; watchdog_expired_out && !wdt_kick_in |=> watchdog_expired_out; endproperty
  property p_wdt_rst; $rose(watchdog_expired_out) |-> ##[0:1] !carrier_reset_n_out; endproperty
  property p_wake; wake_event_out |-> suspend_ram_ind_n_out && !$past(suspend_ram_ind_n_out);
  endproperty
  property p_bat; battery_event_out |-> battery_low_out && !$past(battery_low_out); endproperty
  property p_lid_evt; lid_event_out |-> lid_closed_out != $past(lid_closed_out); endproperty
  property p_lid_q; $rose(lid_closed_out) |-> !$past(lid_n_in, 4) && !$past(lid_n_in, 11);
  endproperty
  a_disk: assert property (p_disk) else $error("disk indicator driven low");
  a_on_ind: assert property (p_on_ind) else $error("reset released outside on");
  a_ram: assert property (p_ram) else $error("ram indicator state wrong");
  a_prep: assert property (p_prep) else $error("imminent lead wrong");
  a_swrst: assert property (p_swrst) else $error("sw reset ignored");
  a_wdt_hold: assert property (p_wdt_hold) else $error("watchdog flag dropped");
  a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog gave no reset");
  a_wake: assert property (p_wake) else $error("wake pulse without exit");
  a_bat: assert property (p_bat) else $error("battery event wrong");
  a_lid_evt: assert property (p_lid_evt) else $error("lid event without change");
  a_lid_q: assert property (p_lid_q) else $error("lid short pulse taken");
  c_ram: cover property (!suspend_ram_ind_n_out);
  c_wdt: cover property ($rose(watchdog_expired_out));
  c_wake: cover property (wake_event_out);
endmodule
bind psm_power_mgr psm_power_mgr_asserts u_psm_power_mgr_asserts (.clk_sys_in, .rst_in,
  .lid_n_in, .sw_reset_req_in, .wdt_kick_in, .carrier_reset_n_out, .suspend_imminent_n_out,
  .suspend_ram_ind_n_out, .suspend_disk_ind_n_out, .soft_off_ind_n_out, .watchdog_expired_out,
  .lid_closed_out, .lid_event_out, .battery_low_out, .battery_event_out, .wake_event_out);

// *** verification/psm_carrier_model.sv ***
/*
  Carrier board model: buttons, supply status and wake sources.
  Assumes pins indexed as the package slots, driven 1 ns after an edge.
*/
`timescale 1ns/1ps
module psm_carrier_model (
  input wire logic clk_sys_in,
  input wire logic suspend_ram_ind_n_in,
  output logic [8:0] pin_out,
  output logic supply_on_request_out
);
  initial pin_out = 9'h0ef;
  assign supply_on_request_out = !suspend_ram_ind_n_in;
  // set a pin level and keep it
  task automatic drive(input int idx, input logic lvl);
    @(posedge clk_sys_in);
    #1 pin_out[idx] = lvl;
  endtask
  // press for len cycles, then restore
  task automatic pulse(input int idx, input logic lvl, input int len);
    drive(idx, lvl);
    repeat (len) @(posedge clk_sys_in);
    #1 pin_out[idx] = !lvl;
  endtask
endmodule

// *** verification/power_system_management_pins_tb.sv ***
/*
  Self-checking bench for psm_power_mgr with short test counts.
  Assumes the carrier model and the bound checker.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s expected %0d seen %0d", nm, e, g); end end
module power_system_management_pins_tb;
  import psm_pkg::*;
  localparam int RST_P = 10;
  localparam int BTN_H = 8;
  logic clk_sys_in = 0, rst_in = 1, sw_reset_req_in = 0, sw_off_req_in = 0, sw_sleep_req_in = 0;
  logic wdt_enable_in = 0, wdt_kick_in = 0, crst, imm, ram, disk, off, wdt, lidc, lidev;
  logic batl, batev, wake, son;
  logic [8:0] pin;
  int fail_count = 0, comparisons = 0, cyc = 0;
  logic [31:0] rng = 32'h84bd987c;
  always #2.5 clk_sys_in = !clk_sys_in;
  psm_power_mgr #(.BTN_HOLD_CYC(BTN_H), .RST_PULSE_CYC(RST_P), .WDT_CYC(50)) u_psm_power_mgr (
    .clk_sys_in, .rst_in, .power_button_n_in(pin[0]), .reset_button_n_in(pin[1]),
    .lid_n_in(pin[2]), .sleep_button_n_in(pin[3]), .supply_good_in(pin[4]),
    .pcie_wake_n_in(pin[5]), .aux_wake_n_in(pin[6]), .battery_low_n_in(pin[7]),
    .main_supply_low_in(pin[8]), .sw_reset_req_in, .sw_sleep_req_in, .sw_off_req_in,
    .wdt_enable_in, .wdt_kick_in, .carrier_reset_n_out(crst), .suspend_imminent_n_out(imm),
    .suspend_ram_ind_n_out(ram), .suspend_disk_ind_n_out(disk), .soft_off_ind_n_out(off),
    .watchdog_expired_out(wdt), .lid_closed_out(lidc), .lid_event_out(lidev),
    .battery_low_out(batl), .battery_event_out(batev), .wake_event_out(wake));
  psm_carrier_model u_psm_carrier_model (.clk_sys_in, .suspend_ram_ind_n_in(ram),
    .pin_out(pin), .supply_on_request_out(son));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic exp_lid(input int len);
    // the model holds the pin low for len + 4 sampled edges
    return len + 4 >= BTN_H;
  endfunction
  task automatic end_of_test();
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_until(input string nm, ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk_sys_in);
      #1 n++;
    end
    `CHK(nm, v, s)
  endtask
  task automatic sw(ref logic s);
    @(posedge clk_sys_in);
    #1 s = 1;
    @(posedge clk_sys_in);
    #1 s = 0;
  endtask
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    int len, n;
    logic seen, closed;
    repeat (2) @(posedge clk_sys_in);
    #1 rst_in = 0;
    `CHK("disk", 1'b1, disk)
    `CHK("off", 1'b0, off)
    u_psm_carrier_model.drive(PSM_IDX_PGOOD, 1);
    repeat (30) @(posedge clk_sys_in);
    u_psm_carrier_model.pulse(PSM_IDX_PWR, 0, 5);
    repeat (20) @(posedge clk_sys_in);
    #1 `CHK("short", 1'b0, off)
    u_psm_carrier_model.pulse(PSM_IDX_PWR, 0, 12);
    wait_until("on", off, 1, 20);
    wait_until("crst", crst, 1, 40);
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      len = rng[0] ? 1 + rng[7:1] % 5 : 12 + rng[7:1] % 9;
      seen = 0;
      closed = 0;
      u_psm_carrier_model.drive(PSM_IDX_LID, 0);
      repeat (len + 3) begin
        @(posedge clk_sys_in);
        #1 seen = seen | lidev;
        closed = closed | lidc;
      end
      u_psm_carrier_model.drive(PSM_IDX_LID, 1);
      repeat (15) begin
        @(posedge clk_sys_in);
        #1 seen = seen | lidev;
        closed = closed | lidc;
      end
      `CHK("lid", exp_lid(len), seen)
      `CHK("lidc", exp_lid(len), closed)
      `CHK("lido", 1'b0, lidc)
    end
    sw(sw_reset_req_in);
    `CHK("swrst", 1'b0, crst)
    n = 0;
    while (crst !== 1'b1 && n < 50) begin
      @(posedge clk_sys_in);
      #1 n++;
    end
    `CHK("rstlen", RST_P, n)
    u_psm_carrier_model.drive(PSM_IDX_RST, 0);
    wait_until("rstbtn", crst, 0, 15);
    wait_until("rsthold", crst, 1, 15);
    u_psm_carrier_model.drive(PSM_IDX_RST, 1);
    wdt_enable_in = 1;
    wait_until("wdt", wdt, 1, 80);
    @(posedge clk_sys_in);
    #1 `CHK("wdtrst", 1'b0, crst)
    wdt_enable_in = 0;
    sw(wdt_kick_in);
    `CHK("kick", 1'b0, wdt)
    wait_until("crst", crst, 1, 20);
    u_psm_carrier_model.drive(PSM_IDX_BAT, 0);
    wait_until("batev", batev, 1, 30);
    `CHK("batl", 1'b1, batl)
    wait_until("imm", imm, 0, 3);
    wait_until("ram", ram, 0, 2010);
    `CHK("son", 1'b1, son)
    u_psm_carrier_model.drive(PSM_IDX_BAT, 1);
    u_psm_carrier_model.drive(PSM_IDX_AUX_WAKE_IN_N, 0);
    wait_until("auxwake", wake, 1, 30);
    `CHK("ramhi", 1'b1, ram)
    u_psm_carrier_model.drive(PSM_IDX_AUX_WAKE_IN_N, 1);
    u_psm_carrier_model.pulse(PSM_IDX_SLP, 0, 12);
    wait_until("sleep", ram, 0, 2010);
    `CHK("batl0", 1'b0, batl)
    u_psm_carrier_model.drive(PSM_IDX_PCIE_WAKE_IN_N, 0);
    wait_until("pciwake", wake, 1, 30);
    u_psm_carrier_model.drive(PSM_IDX_PCIE_WAKE_IN_N, 1);
    wait_until("crst", crst, 1, 30);
    sw(sw_off_req_in);
    wait_until("offimm", imm, 0, 2);
    wait_until("softoff", off, 0, 2010);
    `CHK("offram", 1'b1, ram)
    `CHK("soff", 1'b0, son)
    u_psm_carrier_model.pulse(PSM_IDX_PWR, 0, 12);
    wait_until("on2", off, 1, 20);
    wait_until("crst", crst, 1, 40);
    sw(sw_sleep_req_in);
    wait_until("swsleep", ram, 0, 2010);
    u_psm_carrier_model.pulse(PSM_IDX_PWR, 0, 12);
    wait_until("pwrwake", ram, 1, 20);
    wait_until("crst", crst, 1, 40);
    u_psm_carrier_model.drive(PSM_IDX_MAINLOW, 1);
    wait_until("mainlow", crst, 0, 30);
    u_psm_carrier_model.drive(PSM_IDX_MAINLOW, 0);
    wait_until("crst", crst, 1, 40);
    u_psm_carrier_model.drive(PSM_IDX_PGOOD, 0);
    wait_until("pgood", crst, 0, 30);
    end_of_test();
  end
endmodule
